// ===== rtl/gate_drive_overcurrent_control.sv
// top: pwm input sync, over-current protection, warning, gate outputs
//
// Function
// R1 - never drive both fets of a phase
// R2 - dead time 50 to 500 ns, 50 grounded
// R3 - longer pwm gap honoured, minimum kept
// R4 - 5 bit vds threshold setting
// R5 - gates low when disabled or faulted
// R6 - selectable gate slew setting
// R7 - four amplifier gain choices
// R8 - calibration shorts inputs, disconnects load
// R9 - current limit mode limits and warns
// R10 - warning held for cycle or 64 us
// R11 - new over-current restarts warning hold
// R12 - one bit picks cbc or off-time
// R13 - cbc keeps fet off until next cycle
// R14 - off-time holds fet off 64 us
// R15 - one shared timer for all fets
// R16 - pwm toggle releases held fet early
// R17 - latch mode turns off whole phase
// R18 - report only warns stretched 64 us
// R19 - disable mode ignores over-current
// R20 - rising pwm edge starts cycle
`timescale 1ns/1ps
module gate_drive_overcurrent_control
    import gate_drive_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic gate_enable,
    input wire logic fault_active,
    input wire logic [fets-1:0] pwm_in,
    input wire logic [fets-1:0] vds_over,
    input wire logic [dead_w-1:0] dead_time_setting_input,
    input wire logic [vds_w-1:0] vds_threshold_sel,
    input wire logic [slew_w-1:0] slew_sel,
    input wire logic [gain_w-1:0] amp_gain_sel,
    input wire logic amp_offset_calibrate,
    input wire logic spi_calibrate,
    input wire logic [1:0] overcurrent_mode_select,
    input wire logic cycle_by_cycle_limit,
    input wire logic latch_clear,
    output logic [fets-1:0] gate_out,
    output logic [vds_w-1:0] vds_threshold,
    output logic [slew_w-1:0] gate_slew,
    output logic [gain_w-1:0] amp_gain,
    output logic amp_short_inputs,
    output logic amp_load_disconnect,
    output logic [phases-1:0] oc_status,
    output logic overcurrent_temp_warning_n
);
    // even index is high side, odd index is low side of a phase
    logic [fets-1:0] pwm_m_q;
    logic [fets-1:0] pwm_s_q;
    logic [fets-1:0] pwm_p_q;

    logic [fets-1:0] oc_m_q;
    logic [fets-1:0] oc_s_q;

    logic [fets-1:0] en_m_q;
    logic [fets-1:0] en_s_q;
    logic flt_m_q;
    logic flt_s_q;

    logic cal_m_q;
    logic cal_s_q;

    logic [fets-1:0] hold_q;
    logic [phases-1:0] latch_q;

    logic [fets-1:0] rise;
    logic [fets-1:0] toggle;
    logic [fets-1:0] oc_new;
    logic [fets-1:0] fet_en;

    logic [fets-1:0] warn_cyc_q;
    logic warn_q;
    logic cbc_q;

    logic [dead_w-1:0] dead_cyc;
    overcurrent_mode_select_t mode;
    oc_timer_if tif ();

    assign mode = overcurrent_mode_select_t'(overcurrent_mode_select);

    // pwm, vds, enable, fault and calibrate pins pass two flops; first stage is read only by the second
    // fault synced apart: enable low or latch_clear clears a latch, fault does not
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pwm_m_q <= '0;
            pwm_s_q <= '0;
            pwm_p_q <= '0;
            oc_m_q <= '0;
            oc_s_q <= '0;
            en_m_q <= '0;
            en_s_q <= '0;
            flt_m_q <= 1'b0;
            flt_s_q <= 1'b0;
            cal_m_q <= 1'b0;
            cal_s_q <= 1'b0;
        end
        else
        begin
            pwm_m_q <= pwm_in;
            pwm_s_q <= pwm_m_q;
            pwm_p_q <= pwm_s_q;
            oc_m_q <= vds_over;
            oc_s_q <= oc_m_q;
            en_m_q <= {fets{gate_enable}};
            en_s_q <= en_m_q;
            flt_m_q <= fault_active;
            flt_s_q <= flt_m_q;
            cal_m_q <= amp_offset_calibrate;
            cal_s_q <= cal_m_q;
        end
    end

    // R20 rising edge marks new cycle
    assign rise = pwm_s_q & ~pwm_p_q;
    assign toggle = pwm_s_q ^ pwm_p_q;
    // R19 disable mode ignores detections
    assign oc_new = (mode == oc_disable) ? '0 : (oc_s_q & pwm_s_q & ~hold_q);

    // R2 dead time clamped to range, grounded gives minimum
    always_comb
    begin
        dead_cyc = dead_time_setting_input;
        if (dead_time_setting_input < dead_w'(dead_min_cyc))
        begin
            dead_cyc = dead_w'(dead_min_cyc);
        end
        else if (dead_time_setting_input > dead_w'(dead_max_cyc))
        begin
            dead_cyc = dead_w'(dead_max_cyc);
        end
    end

    // R15 one shared timer restarted by any new event in limit or report mode
    assign tif.restart = (|oc_new) && (mode == oc_limit || mode == oc_report);

    oc_timer u_timer
    (
        .clk(clk),
        .nrst(nrst),
        .t(tif)
    );

    // R12 reset value selects cbc
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cbc_q <= 1'b1;
        end
        else
        begin
            cbc_q <= cycle_by_cycle_limit;
        end
    end

    // per fet current limit hold
    genvar gi;
    generate
        for (gi = 0; gi < fets; gi = gi + 1)
        begin : g_fet
            always_ff @(posedge clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    hold_q[gi] <= 1'b0;
                end
                else if (mode != oc_limit)
                begin
                    hold_q[gi] <= 1'b0;
                end
                // R9 limit by switching the fet off
                else if (oc_new[gi])
                begin
                    hold_q[gi] <= 1'b1;
                end
                // R13 cbc release on next cycle
                else if (cbc_q && rise[gi])
                begin
                    hold_q[gi] <= 1'b0;
                end
                // R16 toggle releases early
                else if (!cbc_q && toggle[gi])
                begin
                    hold_q[gi] <= 1'b0;
                end
                // R14 release after 64 us off time
                else if (!cbc_q && tif.expired)
                begin
                    hold_q[gi] <= 1'b0;
                end
            end

            // warning tracks whether this fet's pwm cycle is still going
            always_ff @(posedge clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    warn_cyc_q[gi] <= 1'b0;
                end
                // stale flags would stretch a later warning
                else if (mode != oc_limit)
                begin
                    warn_cyc_q[gi] <= 1'b0;
                end
                else if (oc_new[gi] && mode == oc_limit)
                begin
                    warn_cyc_q[gi] <= 1'b1;
                end
                else if (!pwm_s_q[gi])
                begin
                    warn_cyc_q[gi] <= 1'b0;
                end
            end

            // R5 gates low while disabled or faulted
            assign fet_en[gi] = en_s_q[gi] && !flt_s_q && !hold_q[gi] && !latch_q[gi / 2];
        end
    endgenerate

    // R17 latch shutdown of whole phase
    genvar pi;
    generate
        for (pi = 0; pi < phases; pi = pi + 1)
        begin : g_phase
            always_ff @(posedge clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    latch_q[pi] <= 1'b0;
                end
                else if (mode == oc_latch && |oc_new[2 * pi + 1 -: 2])
                begin
                    latch_q[pi] <= 1'b1;
                end
                else if (latch_clear || !en_s_q[2 * pi])
                begin
                    latch_q[pi] <= 1'b0;
                end
            end

            // status shows phase with event; set wins over clear
            always_ff @(posedge clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    oc_status[pi] <= 1'b0;
                end
                else if (|oc_new[2 * pi + 1 -: 2])
                begin
                    oc_status[pi] <= 1'b1;
                end
                else if (latch_clear)
                begin
                    oc_status[pi] <= 1'b0;
                end
            end

            // R1 R3 handshake and dead time per phase
            half_bridge u_hb
            (
                .clk(clk),
                .nrst(nrst),
                .want_hi(pwm_s_q[2 * pi] & fet_en[2 * pi]),
                .want_lo(pwm_s_q[2 * pi + 1] & fet_en[2 * pi + 1]),
                .dead_cyc(dead_cyc),
                .gate_hi(gate_out[2 * pi]),
                .gate_lo(gate_out[2 * pi + 1])
            );
        end
    endgenerate

    // R10 R11 warning held for cycle or restarted timer
    // R18 report mode stretches via the timer
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            warn_q <= 1'b0;
        end
        else if (mode == oc_disable)
        begin
            warn_q <= 1'b0;
        end
        else if (|oc_new)
        begin
            warn_q <= 1'b1;
        end
        else if (mode == oc_latch)
        begin
            warn_q <= |latch_q;
        end
        else if (mode == oc_limit)
        begin
            warn_q <= tif.running && (|warn_cyc_q);
        end
        else
        begin
            warn_q <= tif.running;
        end
    end

    assign overcurrent_temp_warning_n = ~warn_q;

    // R4 R6 R7 settings passed to the analog side as registers
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            vds_threshold <= '0;
            gate_slew <= '0;
            amp_gain <= '0;
        end
        else
        begin
            vds_threshold <= vds_threshold_sel;
            gate_slew <= slew_sel;
            amp_gain <= amp_gain_sel;
        end
    end

    // R8 calibration by pin or command
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            amp_short_inputs <= 1'b0;
            amp_load_disconnect <= 1'b0;
        end
        else
        begin
            amp_short_inputs <= cal_s_q | spi_calibrate;
            amp_load_disconnect <= cal_s_q | spi_calibrate;
        end
    end
endmodule

// ===== rtl/gate_drive_pkg.sv
// shared constants and types for the gate drive over-current control
package gate_drive_pkg;
    localparam int unsigned clk_mhz = 125;
    localparam int unsigned phases = 3;
    localparam int unsigned fets = 6;
    // dead time limits in ns
    localparam int unsigned dead_min_ns = 50;
    localparam int unsigned dead_max_ns = 500;
    localparam int unsigned dead_min_cyc = (dead_min_ns * clk_mhz + 999) / 1000;
    localparam int unsigned dead_max_cyc = (dead_max_ns * clk_mhz) / 1000;
    localparam int unsigned dead_w = 7;
    // over-current hold and off time in us
    localparam int unsigned oc_time_us = 64;
    localparam int unsigned oc_time_cyc = oc_time_us * clk_mhz;
    localparam int unsigned oc_cnt_w = 14;
    localparam int unsigned vds_w = 5;
    localparam int unsigned slew_w = 2;
    localparam int unsigned gain_w = 2;
    typedef enum logic [1:0]
    {
        oc_limit = 2'b00,
        oc_latch = 2'b01,
        oc_report = 2'b10,
        oc_disable = 2'b11
    } overcurrent_mode_select_t;
    typedef enum logic [1:0]
    {
        hb_off = 2'b00,
        hb_dead = 2'b01,
        hb_high = 2'b10,
        hb_low = 2'b11
    } hb_state_t;
endpackage

// ===== rtl/half_bridge.sv
// one phase: high/low handshake with dead time
`timescale 1ns/1ps
module half_bridge
    import gate_drive_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic want_hi,
    input wire logic want_lo,
    input wire logic [dead_w-1:0] dead_cyc,
    output logic gate_hi,
    output logic gate_lo
);
    hb_state_t st_q;
    logic [dead_w-1:0] cnt_q;
    logic next_hi_q;

    // R1 handshake state machine
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_q <= hb_off;
            cnt_q <= '0;
            next_hi_q <= 1'b0;
        end
        else
        begin
            case (st_q)
                hb_off:
                begin
                    // R3 dead time runs from the off edge
                    if (cnt_q != '0)
                    begin
                        cnt_q <= cnt_q - dead_w'(1);
                    end
                    // both requested is treated as neither
                    if (want_hi != want_lo)
                    begin
                        st_q <= hb_dead;
                        next_hi_q <= want_hi;
                    end
                end
                hb_dead:
                begin
                    // R2 dead time count
                    if (cnt_q > dead_w'(1))
                    begin
                        cnt_q <= cnt_q - dead_w'(1);
                    end
                    // R3 external gap honoured
                    else if (next_hi_q && want_hi && !want_lo)
                    begin
                        st_q <= hb_high;
                    end
                    else if (!next_hi_q && want_lo && !want_hi)
                    begin
                        st_q <= hb_low;
                    end
                    else
                    begin
                        st_q <= hb_off;
                    end
                end
                hb_high:
                begin
                    if (!want_hi || want_lo)
                    begin
                        st_q <= hb_off;
                        cnt_q <= dead_cyc;
                    end
                end
                hb_low:
                begin
                    if (!want_lo || want_hi)
                    begin
                        st_q <= hb_off;
                        cnt_q <= dead_cyc;
                    end
                end
                default:
                begin
                    st_q <= hb_off;
                end
            endcase
        end
    end

    // registered outputs drop on the next clock edge after the request goes away
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            gate_hi <= 1'b0;
            gate_lo <= 1'b0;
        end
        else
        begin
            gate_hi <= (st_q == hb_high) && want_hi && !want_lo;
            gate_lo <= (st_q == hb_low) && want_lo && !want_hi;
        end
    end
endmodule

// ===== rtl/oc_timer.sv
// single shared 64 us timer, restarted by any new over-current event in limit or report mode
`timescale 1ns/1ps
module oc_timer
    import gate_drive_pkg::*;
#(
    parameter logic [oc_cnt_w-1:0] period_cyc = oc_cnt_w'(oc_time_cyc)
)
(
    input wire logic clk,
    input wire logic nrst,
    oc_timer_if.tmr t
);
    logic [oc_cnt_w-1:0] cnt_q;
    logic run_q;
    logic exp_q;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt_q <= '0;
            run_q <= 1'b0;
            exp_q <= 1'b0;
        end
        else if (t.restart)
        begin
            cnt_q <= period_cyc;
            run_q <= 1'b1;
            exp_q <= 1'b0;
        end
        else if (run_q)
        begin
            cnt_q <= cnt_q - oc_cnt_w'(1);
            if (cnt_q == oc_cnt_w'(1))
            begin
                run_q <= 1'b0;
                exp_q <= 1'b1;
            end
        end
        else
        begin
            exp_q <= 1'b0;
        end
    end

    assign t.running = run_q;
    assign t.expired = exp_q;
endmodule

// ===== rtl/oc_timer_if.sv
// shared 64 us timer connection between protection and timer
`timescale 1ns/1ps
interface oc_timer_if;
    import gate_drive_pkg::*;
    logic restart;
    logic running;
    logic expired;
    modport ctrl (output restart, input running, input expired);
    modport tmr (input restart, output running, output expired);
endinterface

// ===== verification/gate_drive_overcurrent_control_test.sv
// self-checking bench for the gate drive over-current control
`timescale 1ns/1ps
module gate_drive_overcurrent_control_test;
    import gate_drive_pkg::*;
    logic clk, nrst, gate_enable, fault_active, amp_offset_calibrate, spi_calibrate;
    logic cycle_by_cycle_limit, latch_clear, amp_short_inputs, amp_load_disconnect;
    logic overcurrent_temp_warning_n;
    logic [fets-1:0] want, pwm_in, vds_over, gate_out;
    logic [7:0] gap;
    logic [dead_w-1:0] dead_time_setting_input;
    logic [vds_w-1:0] vds_threshold_sel, vds_threshold;
    logic [slew_w-1:0] slew_sel, gate_slew;
    logic [gain_w-1:0] amp_gain_sel, amp_gain;
    logic [1:0] overcurrent_mode_select;
    logic [phases-1:0] oc_status;
    int fails = 0;
    int n_tests = 0;
    int n;
    pwm_host host_u (.clk(clk), .nrst(nrst), .want(want), .gap(gap), .pwm_in(pwm_in));
    gate_drive_overcurrent_control dut_u (.clk(clk), .nrst(nrst), .gate_enable(gate_enable),
        .fault_active(fault_active), .pwm_in(pwm_in), .vds_over(vds_over),
        .dead_time_setting_input(dead_time_setting_input),
        .vds_threshold_sel(vds_threshold_sel), .slew_sel(slew_sel),
        .amp_gain_sel(amp_gain_sel), .amp_offset_calibrate(amp_offset_calibrate),
        .spi_calibrate(spi_calibrate), .overcurrent_mode_select(overcurrent_mode_select),
        .cycle_by_cycle_limit(cycle_by_cycle_limit), .latch_clear(latch_clear),
        .gate_out(gate_out), .vds_threshold(vds_threshold), .gate_slew(gate_slew),
        .amp_gain(amp_gain), .amp_short_inputs(amp_short_inputs),
        .amp_load_disconnect(amp_load_disconnect), .oc_status(oc_status),
        .overcurrent_temp_warning_n(overcurrent_temp_warning_n));
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // off cycles on phase 0 while the low side takes over
    task automatic gap_lo(output int k);
        int i;
        k = 0;
        want = 6'h02;
        for (i = 0; i < 400 && gate_out[1] !== 1'b1; i++)
        begin
            if (gate_out[1:0] === 2'b00)
                k++;
            cyc(1);
        end
        if (i == 400)
        begin
            fails++;
            results();
        end
    endtask
    // short over-current pulse, long enough to pass the synchronisers
    task automatic oc(input logic [fets-1:0] f);
        vds_over = f;
        cyc(5);
        vds_over = 6'h00;
        cyc(10);
    endtask
    task automatic clear_on(input logic [1:0] m, input logic [fets-1:0] w);
        overcurrent_mode_select = m;
        latch_clear = 1'b1;
        cyc(1);
        latch_clear = 1'b0;
        want = w;
        cyc(30);
    endtask
    initial
    begin
        {nrst, gate_enable, fault_active, amp_offset_calibrate, spi_calibrate} = 5'h00;
        {latch_clear, want, gap, vds_over, dead_time_setting_input} = 28'h0;
        {vds_threshold_sel, slew_sel, amp_gain_sel, overcurrent_mode_select} = 11'h0;
        cycle_by_cycle_limit = 1'b1;
        cyc(4);
        nrst = 1'b1;
        cyc(3);
        chk("gates", 8'h00, 8'(gate_out));
        chk("warn", 8'h01, 8'(overcurrent_temp_warning_n));
        chk("status", 8'h00, 8'(oc_status));
        $display("test reset done");
        for (int i = 0; i < 4; i++)
        begin
            vds_threshold_sel = 5'(i * 7 + 3);
            slew_sel = 2'(i);
            amp_gain_sel = 2'(3 - i);
            cyc(2);
            chk("threshold", 8'(i * 7 + 3), 8'(vds_threshold));
            chk("slew", 8'(i), 8'(gate_slew));
            chk("gain", 8'(3 - i), 8'(amp_gain));
        end
        vds_threshold_sel = 5'h1f;
        cyc(2);
        chk("threshold", 8'h1f, 8'(vds_threshold));
        // calibrate while the gates are off
        spi_calibrate = 1'b1;
        cyc(2);
        chk("cal", 8'h03, 8'({amp_short_inputs, amp_load_disconnect}));
        spi_calibrate = 1'b0;
        amp_offset_calibrate = 1'b1;
        cyc(4);
        chk("cal pin", 8'h03, 8'({amp_short_inputs, amp_load_disconnect}));
        amp_offset_calibrate = 1'b0;
        cyc(4);
        chk("cal off", 8'h00, 8'({amp_short_inputs, amp_load_disconnect}));
        $display("test settings done");
        gate_enable = 1'b1;
        want = 6'h01;
        cyc(30);
        chk("gates", 8'h01, 8'(gate_out));
        gap_lo(n);
        chk("dead min", 8'h01, 8'(n >= 7 && n <= 23));
        dead_time_setting_input = 7'h28;
        want = 6'h01;
        cyc(80);
        gap_lo(n);
        chk("dead set", 8'h01, 8'(n >= 40 && n <= 56));
        dead_time_setting_input = 7'h00;
        gap = 8'h3c;
        want = 6'h01;
        cyc(80);
        gap_lo(n);
        chk("long gap", 8'h01, 8'(n >= 60 && n <= 66));
        gap = 8'h00;
        gate_enable = 1'b0;
        cyc(5);
        chk("enable low", 8'h00, 8'(gate_out));
        gate_enable = 1'b1;
        cyc(30);
        chk("enable high", 8'h02, 8'(gate_out));
        fault_active = 1'b1;
        cyc(5);
        chk("fault", 8'h00, 8'(gate_out));
        fault_active = 1'b0;
        $display("test drive done");
        clear_on(2'b00, 6'h01);
        oc(6'h01);
        chk("cbc gates", 8'h00, 8'(gate_out));
        chk("cbc warn", 8'h00, 8'(overcurrent_temp_warning_n));
        chk("cbc status", 8'h01, 8'(oc_status));
        cyc(50);
        chk("cbc held", 8'h00, 8'(gate_out));
        want = 6'h00;
        cyc(10);
        chk("cbc warn end", 8'h01, 8'(overcurrent_temp_warning_n));
        want = 6'h01;
        cyc(30);
        chk("cbc new cycle", 8'h01, 8'(gate_out));
        $display("test cbc done");
        cycle_by_cycle_limit = 1'b0;
        clear_on(2'b00, 6'h05);
        oc(6'h01);
        cyc(985);
        oc(6'h04);
        cyc(7500);
        chk("shared timer", 8'h00, 8'(gate_out));
        chk("warn restart", 8'h00, 8'(overcurrent_temp_warning_n));
        cyc(600);
        chk("off time end", 8'h05, 8'(gate_out));
        chk("warn end", 8'h01, 8'(overcurrent_temp_warning_n));
        oc(6'h05);
        cyc(100);
        want = 6'h04;
        cyc(5);
        want = 6'h05;
        cyc(30);
        chk("toggle resume", 8'h01, 8'(gate_out));
        cyc(8000);
        chk("timer resume", 8'h05, 8'(gate_out));
        $display("test off time done");
        clear_on(2'b01, 6'h01);
        oc(6'h01);
        chk("latch gates", 8'h00, 8'(gate_out));
        chk("latch status", 8'h01, 8'(oc_status));
        want = 6'h02;
        cyc(30);
        chk("latch phase", 8'h00, 8'(gate_out));
        clear_on(2'b01, 6'h02);
        chk("latch clear", 8'h02, 8'(gate_out));
        $display("test latch done");
        clear_on(2'b10, 6'h01);
        oc(6'h01);
        chk("report gates", 8'h01, 8'(gate_out));
        chk("report status", 8'h01, 8'(oc_status));
        cyc(7900);
        chk("report stretch", 8'h00, 8'(overcurrent_temp_warning_n));
        cyc(200);
        chk("report end", 8'h01, 8'(overcurrent_temp_warning_n));
        $display("test report done");
        clear_on(2'b11, 6'h01);
        oc(6'h01);
        chk("off gates", 8'h01, 8'(gate_out));
        chk("off warn", 8'h01, 8'(overcurrent_temp_warning_n));
        chk("off status", 8'h00, 8'(oc_status));
        $display("test disable done");
        results();
    end
endmodule

// ===== verification/gate_drive_properties.sv
// concurrent checks on the gate drive over-current control ports
`timescale 1ns/1ps
module gate_drive_checks
    import gate_drive_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic gate_enable,
    input wire logic fault_active,
    input wire logic [fets-1:0] vds_over,
    input wire logic [vds_w-1:0] vds_threshold_sel,
    input wire logic [gain_w-1:0] amp_gain_sel,
    input wire logic spi_calibrate,
    input wire logic [1:0] overcurrent_mode_select,
    input wire logic [fets-1:0] gate_out,
    input wire logic [vds_w-1:0] vds_threshold,
    input wire logic [gain_w-1:0] amp_gain,
    input wire logic amp_short_inputs,
    input wire logic amp_load_disconnect,
    input wire logic [phases-1:0] oc_status,
    input wire logic overcurrent_temp_warning_n
);
    // a few cycles of slack for the input synchronisers
    localparam int hold_min = oc_time_cyc - 4;
    logic [15:0] low_cnt_q;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    // saturating count of warning low cycles
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            low_cnt_q <= 16'h0000;
        else if (overcurrent_temp_warning_n)
            low_cnt_q <= 16'h0000;
        else if (low_cnt_q != 16'hffff)
            low_cnt_q <= low_cnt_q + 16'h0001;
    end
    property p_no_shoot;
        (gate_out & {gate_out[4:0], 1'b0} & 6'h2a) == 6'h00;
    endproperty
    a_no_shoot: assert property (p_no_shoot)
        else $error("both fets of a phase on");
    property p_dead_min;
        $fell(gate_out[0]) |-> (!gate_out[1])[*7];
    endproperty
    a_dead_min: assert property (p_dead_min)
        else $error("dead time too short");
    property p_vds_set;
        $stable(vds_threshold_sel)[*2] |-> vds_threshold == vds_threshold_sel;
    endproperty
    a_vds_set: assert property (p_vds_set)
        else $error("threshold setting not applied");
    property p_gates_off;
        (!gate_enable || fault_active)[*4] |=> gate_out == 6'h00;
    endproperty
    a_gates_off: assert property (p_gates_off)
        else $error("gates on while disabled");
    property p_gain_set;
        $stable(amp_gain_sel)[*2] |-> amp_gain == amp_gain_sel;
    endproperty
    a_gain_set: assert property (p_gain_set)
        else $error("gain setting not applied");
    property p_cal;
        spi_calibrate |=> amp_short_inputs && amp_load_disconnect;
    endproperty
    a_cal: assert property (p_cal)
        else $error("calibration not applied");
    property p_limit_warn;
        (overcurrent_mode_select == 2'b00 && vds_over[0] && gate_out[0])[*2]
            |-> ##[1:6] !overcurrent_temp_warning_n;
    endproperty
    a_limit_warn: assert property (p_limit_warn)
        else $error("no warning in limit mode");
    property p_latch_phase;
        (overcurrent_mode_select == 2'b01 && vds_over[0] && gate_out[0])[*2]
            |-> ##[1:6] gate_out[1:0] == 2'b00;
    endproperty
    a_latch_phase: assert property (p_latch_phase)
        else $error("phase not shut down");
    property p_report_hold;
        overcurrent_mode_select == 2'b10 && $rose(overcurrent_temp_warning_n)
            |-> low_cnt_q >= hold_min;
    endproperty
    a_report_hold: assert property (p_report_hold)
        else $error("report warning too short");
    property p_disable;
        (overcurrent_mode_select == 2'b11)[*4]
            |-> !$fell(overcurrent_temp_warning_n) && (oc_status & ~$past(oc_status)) == 3'h0;
    endproperty
    a_disable: assert property (p_disable)
        else $error("over-current reported while disabled");
endmodule

bind gate_drive_overcurrent_control gate_drive_checks chk_u (.clk(clk), .nrst(nrst),
    .gate_enable(gate_enable), .fault_active(fault_active), .vds_over(vds_over),
    .vds_threshold_sel(vds_threshold_sel), .amp_gain_sel(amp_gain_sel),
    .spi_calibrate(spi_calibrate), .overcurrent_mode_select(overcurrent_mode_select),
    .gate_out(gate_out), .vds_threshold(vds_threshold), .amp_gain(amp_gain),
    .amp_short_inputs(amp_short_inputs), .amp_load_disconnect(amp_load_disconnect),
    .oc_status(oc_status), .overcurrent_temp_warning_n(overcurrent_temp_warning_n));

// ===== verification/pwm_host.sv
// controller model: drops pwm first, waits a gap, then raises
`timescale 1ns/1ps
module pwm_host
    import gate_drive_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [fets-1:0] want,
    input wire logic [7:0] gap,
    output logic [fets-1:0] pwm_in
);
    logic [7:0] wait_q;
    always @(negedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pwm_in <= 6'h00;
            wait_q <= 8'h00;
        end
        else if (wait_q != 8'h00)
            wait_q <= wait_q - 8'h01;
        else if ((pwm_in & ~want) != 6'h00)
        begin
            pwm_in <= pwm_in & want;
            wait_q <= gap;
        end
        else
            pwm_in <= want;
    end
endmodule
